// [verilog/ass_top.sv]
// two-axis synchronous-start block: register file, interrupt logic, two axis controllers
// assumes motion events and busy levels come from logic on ref_clk; register port never waits
// Overview of operation
// - Start-method code 10 arms for an internal sync pulse and 11 arms for a watched axis stopping.
// - The watched-axis field at bits 20-21 picks X (01), Y (10) or both (11).
// - Bit 29 of env config 2 selects legacy (0) or enhanced (1) start-on-stop behaviour.
// - Legacy needs a stopped axis to see a watched axis stop; enhanced lets a running axis name itself.
// - Timing codes 0001-0101 fire the sync pulse on comparator 1-5 becoming satisfied.
// - Codes 1000-1011 fire on accel start, accel done, decel start and decel done.
// - Any other timing code never fires a sync pulse.
// - Sync input source code 00 in bits 20-21 of env config 5 takes the X axis pulse.
// - Source code 01 takes the Y axis pulse.
// - An axis armed on a stop starts once the watched axis stops after operating.
// - Extension status shows 0011 while awaiting sync and 0100 while awaiting a stop.
// - An enabled event raises the interrupt output in the cycle its sync event is produced.
// - Enable bits 4-7 cover accel start, accel done, decel start and decel done.
// - Cause bits 4-7 record accel start, accel done, decel start and decel done.
// - Cause bits 8-12 record comparators 1 to 5.
`timescale 1ns/1ns
module ass_top import ass_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire ass_events_t ev_x,
   input wire ass_events_t ev_y,
   input wire logic start_cmd_x,
   input wire logic start_cmd_y,
   input wire logic busy_x,
   input wire logic busy_y,
   output logic go_x,
   output logic go_y,
   output logic sync_x,
   output logic sync_y,
   output logic irq
);
   logic [31:0] mode_r [2];
   logic [31:0] env2_r [2];
   logic [31:0] env5_r [2];
   logic [31:0] irq_en_r [2];
   logic [31:0] cause_r [2];
   logic [31:0] rdata_r;
   logic irq_r;
   logic busy_x_d_r, busy_y_d_r;
   wire logic sp [2];
   wire logic go [2];
   wire logic [3:0] wcode [2];

   // stop edges: operating to stopped, seen in the same cycle the busy level drops
   wire logic x_stop_edge = busy_x_d_r & !busy_x;
   wire logic y_stop_edge = busy_y_d_r & !busy_y;
   wire logic sel_axis = reg_addr[5];
   wire logic [5:0] sub_addr = reg_addr & ~AXIS_STRIDE;
   wire ass_events_t evs [2];
   assign evs[0] = ev_x;
   assign evs[1] = ev_y;
   wire logic start_cmd [2];
   assign start_cmd[0] = start_cmd_x;
   assign start_cmd[1] = start_cmd_y;
   wire logic busy [2];
   assign busy[0] = busy_x;
   assign busy[1] = busy_y;

   genvar a;
   generate
      for (a = 0; a < 2; a++) begin : g_axis
         wire logic [1:0] syi = env5_r[a][SYI_LSB +: 2];
         // 10 and 11 for the source are not used here and leave the input quiet
         wire logic sync_in = (syi == SYI_X) ? sp[0] : (syi == SYI_Y) ? sp[1] : 1'b0;
         wire logic [8:0] ev_bits = evs[a];
         // cause tracks each enabled event; set wins over a write-one clear
         wire logic [8:0] en_bits = irq_en_r[a][EV_LSB +: EV_N];
         wire logic [8:0] hit = ev_bits & en_bits;
         wire logic wr_hit = reg_wr && sel_axis == 1'(a);
         wire logic [8:0] clr = (wr_hit && sub_addr == OFS_IRQ_CAUSE) ? reg_wdata[EV_LSB +: EV_N] : 9'h000;

         ass_axis u_axis (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .mode_r(mode_r[a]),
            .smax(env2_r[a][SMAX_BIT]),
            .syo(env5_r[a][SYO_LSB +: 4]),
            .ev(evs[a]),
            .start_cmd(start_cmd[a]),
            .busy(busy[a]),
            .own_stop_edge(a == 0 ? x_stop_edge : y_stop_edge),
            .x_stop_edge(x_stop_edge),
            .y_stop_edge(y_stop_edge),
            .x_idle(!busy_x),
            .y_idle(!busy_y),
            .sync_in(sync_in),
            .sync_pulse_r(sp[a]),
            .go_r(go[a]),
            .wait_code(wcode[a])
         );

         always_ff @(posedge ref_clk or negedge nrst) begin
            if (!nrst) begin
               mode_r[a] <= RST_WORD;
               env2_r[a] <= RST_WORD;
               env5_r[a] <= RST_WORD;
               irq_en_r[a] <= RST_WORD;
               cause_r[a] <= RST_WORD;
            end else begin
               if (wr_hit && sub_addr == OFS_MODE) mode_r[a] <= reg_wdata;
               if (wr_hit && sub_addr == OFS_ENV2) env2_r[a] <= reg_wdata;
               if (wr_hit && sub_addr == OFS_ENV5) env5_r[a] <= reg_wdata;
               if (wr_hit && sub_addr == OFS_IRQ_EN) irq_en_r[a] <= reg_wdata;
               cause_r[a][EV_LSB +: EV_N] <= (cause_r[a][EV_LSB +: EV_N] & ~clr) | hit;
            end
         end

         cause_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
            hit[0] |=> cause_r[a][EV_LSB]) else $error("accel start cause not set");
         cmp_cause_a: assert property (@(posedge ref_clk) disable iff (!nrst)
            hit[4] |=> cause_r[a][EV_LSB + 4]) else $error("cmp1 cause not set");
         no_cause_a: assert property (@(posedge ref_clk) disable iff (!nrst)
            (!en_bits[8] && !cause_r[a][EV_LSB + 8] && !clr[8]) |=> !cause_r[a][EV_LSB + 8])
            else $error("cmp5 cause without enable");
      end
   endgenerate

   // interrupt follows the cycle after the event, matching when the sync pulse leaves its flop
   wire logic irq_nxt = (|(g_axis[0].hit)) | (|(g_axis[1].hit)) |
                        (|(cause_r[0][EV_LSB +: EV_N] & ~g_axis[0].clr)) |
                        (|(cause_r[1][EV_LSB +: EV_N] & ~g_axis[1].clr));

   wire logic [31:0] rd_word [2];
   assign rd_word[0] = (sub_addr == OFS_XSTS) ? {28'h0000000, wcode[0]} :
                       (sub_addr == OFS_IRQ_CAUSE) ? cause_r[0] : 32'h0000_0000;
   assign rd_word[1] = (sub_addr == OFS_XSTS) ? {28'h0000000, wcode[1]} :
                       (sub_addr == OFS_IRQ_CAUSE) ? cause_r[1] : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_r <= RST_WORD;
         irq_r <= 1'b0;
         busy_x_d_r <= 1'b0;
         busy_y_d_r <= 1'b0;
      end else begin
         rdata_r <= reg_rd ? rd_word[sel_axis] : 32'h0000_0000;
         irq_r <= irq_nxt;
         busy_x_d_r <= busy_x;
         busy_y_d_r <= busy_y;
      end
   end

   assign reg_rdata = rdata_r;
   assign irq = irq_r;
   assign go_x = go[0];
   assign go_y = go[1];
   assign sync_x = sp[0];
   assign sync_y = sp[1];

   wire logic u_state_wait_x = (wcode[0] == WAIT_SYNC) && !busy_x;
   irq_with_sync_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (g_axis[0].hit != 9'h000) |=> irq) else $error("irq missing with enabled event");
   route_y_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (env5_r[0][SYI_LSB +: 2] == SYI_Y && sp[1] && u_state_wait_x) |=> go_x)
      else $error("y pulse not routed to x");
   wait_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (start_cmd_x && wcode[0] == WAIT_NONE && mode_r[0][MSY_LSB +: 2] == MSY_STOP) |=> wcode[0] == WAIT_STOP)
      else $error("stop wait not reported");
endmodule : ass_top

// [common/ass_pkg.sv]
// package for the two-axis synchronous-start block: register map, field layout, codes
// assumes a single 20 MHz reference clock and a plain strobe register port
package ass_pkg;
   localparam int ADDR_W = 6;
   // per-axis register offsets; the Y axis copies sit at AXIS_STRIDE above the X axis
   localparam logic [5:0] AXIS_STRIDE = 6'h20;
   localparam logic [5:0] OFS_MODE = 6'h00;
   localparam logic [5:0] OFS_ENV2 = 6'h04;
   localparam logic [5:0] OFS_ENV5 = 6'h08;
   localparam logic [5:0] OFS_XSTS = 6'h0C;
   localparam logic [5:0] OFS_IRQ_EN = 6'h10;
   localparam logic [5:0] OFS_IRQ_CAUSE = 6'h14;
   // field positions
   localparam int MSY_LSB = 18;
   localparam int MAX_LSB = 20;
   localparam int SMAX_BIT = 29;
   localparam int SYO_LSB = 16;
   localparam int SYI_LSB = 20;
   localparam int EV_LSB = 4;
   localparam int EV_N = 9;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // start methods
   localparam logic [1:0] MSY_SYNC = 2'h2;
   localparam logic [1:0] MSY_STOP = 2'h3;
   // watched axis
   localparam logic [1:0] MAX_X = 2'h1;
   localparam logic [1:0] MAX_Y = 2'h2;
   localparam logic [1:0] MAX_XY = 2'h3;
   // sync input source
   localparam logic [1:0] SYI_X = 2'h0;
   localparam logic [1:0] SYI_Y = 2'h1;
   // output timing codes
   localparam logic [3:0] SYO_CMP1 = 4'h1;
   localparam logic [3:0] SYO_CMP5 = 4'h5;
   localparam logic [3:0] SYO_ACC_START = 4'h8;
   localparam logic [3:0] SYO_DEC_DONE = 4'hB;
   // waiting-state codes
   localparam logic [3:0] WAIT_SYNC = 4'h3;
   localparam logic [3:0] WAIT_STOP = 4'h4;
   localparam logic [3:0] WAIT_NONE = 4'h0;

   // one axis's motion events: bit 0..3 accel start, accel done, decel start, decel done; 4..8 cmp 1..5
   typedef struct packed {
      logic [4:0] cmp;
      logic decel_done;
      logic decel_start;
      logic accel_done;
      logic accel_start;
   } ass_events_t;

   typedef enum logic [1:0] {
      ASS_IDLE = 2'b00,
      ASS_WAIT_SYNC = 2'b01,
      ASS_WAIT_STOP = 2'b10
   } ass_state_t;
endpackage : ass_pkg

// [verilog/ass_axis.sv]
// one axis of synchronous-start control: arming, waiting, sync pulse generation
// assumes event inputs are one-cycle pulses from logic on the same clock
`timescale 1ns/1ns
module ass_axis import ass_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic [31:0] mode_r,
   input wire logic smax,
   input wire logic [3:0] syo,
   input wire ass_events_t ev,
   input wire logic start_cmd,
   input wire logic busy,
   input wire logic own_stop_edge,
   input wire logic x_stop_edge,
   input wire logic y_stop_edge,
   input wire logic x_idle,
   input wire logic y_idle,
   input wire logic sync_in,
   output logic sync_pulse_r,
   output logic go_r,
   output logic [3:0] wait_code
);
   ass_state_t state_r, state_nxt;
   wire logic [1:0] msy = mode_r[MSY_LSB +: 2];
   wire logic [1:0] wax = mode_r[MAX_LSB +: 2];
   wire logic [8:0] evb = ev;
   // comparator codes pick cmp bits, accel/decel codes pick bits 0..3; all else never fires
   wire logic cmp_hit = (syo >= SYO_CMP1) && (syo <= SYO_CMP5) && evb[4 + 32'(syo - SYO_CMP1)];
   wire logic ad_hit = (syo >= SYO_ACC_START) && (syo <= SYO_DEC_DONE) && evb[32'(syo - SYO_ACC_START)];
   wire logic sync_fire = cmp_hit | ad_hit;
   // stop condition: a watched axis must go from operating to stopped
   wire logic stop_x = x_stop_edge;
   wire logic stop_y = y_stop_edge;
   wire logic both_stop = (x_stop_edge & (y_idle | y_stop_edge)) | (y_stop_edge & (x_idle | x_stop_edge));
   wire logic stop_hit = (wax == MAX_X) ? stop_x : (wax == MAX_Y) ? stop_y : (wax == MAX_XY) ? both_stop : 1'b0;
   // legacy ignores the axis's own stop edge, so an operating axis cannot start itself
   wire logic arm_ok = !busy && (smax || !own_stop_edge);
   wire logic arm_now = start_cmd && (msy == MSY_SYNC || msy == MSY_STOP);

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ASS_IDLE: begin
            if (arm_now && msy == MSY_SYNC) state_nxt = ASS_WAIT_SYNC;
            else if (arm_now) state_nxt = ASS_WAIT_STOP;
         end
         ASS_WAIT_SYNC: begin
            if (sync_in && !busy) state_nxt = ASS_IDLE;
         end
         ASS_WAIT_STOP: begin
            if (stop_hit && arm_ok) state_nxt = ASS_IDLE;
         end
         default: state_nxt = ASS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state_r <= ASS_IDLE;
         sync_pulse_r <= 1'b0;
         go_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         sync_pulse_r <= sync_fire;
         go_r <= (state_r != ASS_IDLE) && (state_nxt == ASS_IDLE);
      end
   end

   assign wait_code = (state_r == ASS_WAIT_SYNC) ? WAIT_SYNC : (state_r == ASS_WAIT_STOP) ? WAIT_STOP : WAIT_NONE;

   pulse_one_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      sync_pulse_r |-> ($past(sync_fire))) else $error("sync pulse without event");
   bad_code_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (syo > SYO_CMP5 && syo < SYO_ACC_START) || syo > SYO_DEC_DONE || syo == 4'h0 |-> !sync_fire)
      else $error("sync from undefined code");
   sync_start_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_r == ASS_WAIT_SYNC && sync_in && !busy) |=> go_r) else $error("no start after sync");
   legacy_self_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (state_r == ASS_WAIT_STOP && busy && !smax) |=> !go_r) else $error("legacy start while busy");
endmodule : ass_axis

// [tb/ass_far_model.sv]
// far-side model: one axis pulse generator, its busy level and motion events
// assumes bench requests arrive just after a rising edge of ref_clk
`timescale 1ns/1ns
module ass_far_model import ass_pkg::*; (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic run_go,
   input wire logic [7:0] run_len,
   input wire ass_events_t ev_req,
   output logic busy,
   output ass_events_t ev
);
   logic [7:0] cnt_r;
   // events pass through; the bench shapes them as one-cycle pulses
   assign ev = ev_req;
   assign busy = cnt_r != 8'h00;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) cnt_r <= 8'h00;
      else if (run_go) cnt_r <= run_len;
      else if (busy) cnt_r <= cnt_r - 8'h01;
   end
endmodule : ass_far_model

// [tb/tb_top.sv]
// self-checking bench for the two-axis synchronous-start block
// assumes the far-side models stand in for both pulse generators
`timescale 1ns/1ns
module tb_top import ass_pkg::*; ();
   logic ref_clk = 1'b0;
   logic nrst = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0, reg_rdata, rd_v;
   logic reg_wr = 1'b0, reg_rd = 1'b0, en, seen = 1'b0;
   logic [1:0] start_cmd = 2'b00, run_go = 2'b00;
   logic [7:0] run_len = 8'h00;
   ass_events_t evq_x = '0, evq_y = '0, ev_x, ev_y;
   logic busy_x, busy_y, go_x, go_y, sync_x, sync_y, irq;
   int err_count = 0, n_compared = 0, cycles = 0;

   ass_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ev_x(ev_x), .ev_y(ev_y),
      .start_cmd_x(start_cmd[0]), .start_cmd_y(start_cmd[1]), .busy_x(busy_x), .busy_y(busy_y),
      .go_x(go_x), .go_y(go_y), .sync_x(sync_x), .sync_y(sync_y), .irq(irq));
   ass_far_model u_far_x (.ref_clk(ref_clk), .nrst(nrst), .run_go(run_go[0]), .run_len(run_len),
      .ev_req(evq_x), .busy(busy_x), .ev(ev_x));
   ass_far_model u_far_y (.ref_clk(ref_clk), .nrst(nrst), .run_go(run_go[1]), .run_len(run_len),
      .ev_req(evq_y), .busy(busy_y), .ev(ev_y));

   initial forever #25 ref_clk = ~ref_clk;

   function automatic logic [5:0] ba(input int a);
      return a ? AXIS_STRIDE : 6'h00;
   endfunction : ba
   function automatic logic exp_sync(input int c, input int i);
      if (c >= 1 && c <= 5) return i == c + 3;
      if (c >= 8 && c <= 11) return i == c - 8;
      return 1'b0;
   endfunction : exp_sync
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: %s got %0h exp %0h", $time, msg, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      @(posedge ref_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge ref_clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d);
      @(posedge ref_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
      @(posedge ref_clk) reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   task automatic pulse_ev(input int y, input int i);
      @(posedge ref_clk) if (y) evq_y <= ass_events_t'(9'h001 << i); else evq_x <= ass_events_t'(9'h001 << i);
      @(posedge ref_clk) begin evq_x <= '0; evq_y <= '0; end
      #1;
   endtask : pulse_ev
   task automatic start(input int a);
      @(posedge ref_clk) start_cmd[a] <= 1'b1;
      @(posedge ref_clk) start_cmd[a] <= 1'b0;
   endtask : start
   task automatic run(input int a, input logic [7:0] n);
      @(posedge ref_clk) begin run_go[a] <= 1'b1; run_len <= n; end
      @(posedge ref_clk) run_go[a] <= 1'b0;
   endtask : run
   task automatic arm_stop(input int a, input logic [1:0] ax);
      wr(ba(a) + OFS_MODE, (32'(MSY_STOP) << MSY_LSB) | (32'(ax) << MAX_LSB));
      start(a);
   endtask : arm_stop
   // need masks the axes that must already be stopped when the start fires
   task automatic wait_go(input int a, input logic [1:0] need);
      logic hit = 1'b0;
      for (int k = 0; k < 24 && !hit; k++) begin
         @(posedge ref_clk);
         #1 hit = a ? go_y : go_x;
      end
      chk(hit, 1, "no start");
      chk({busy_y, busy_x} & need, 0, "early start");
   endtask : wait_go
   task automatic sync_case(input int w, input int s, input logic [3:0] code, input int i);
      wr(ba(w) + OFS_MODE, 32'(MSY_SYNC) << MSY_LSB);
      wr(ba(w) + OFS_ENV5, 32'(s ? SYI_Y : SYI_X) << SYI_LSB);
      wr(ba(s) + OFS_ENV5, 32'(code) << SYO_LSB);
      start(w);
      rd(ba(w) + OFS_XSTS, rd_v);
      chk(rd_v, 32'(WAIT_SYNC), "wait sync");
      pulse_ev(s, i);
      chk(s ? sync_y : sync_x, 1, "sync");
      @(posedge ref_clk);
      #1 chk(w ? go_y : go_x, 1, "sync start");
      rd(ba(w) + OFS_XSTS, rd_v);
      chk(rd_v, 32'(WAIT_NONE), "idle");
   endtask : sync_case

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         err_count++;
         print_verdict();
      end
   end

   initial begin
      rd_v = $urandom(32'hB1E2);
      repeat (6) @(posedge ref_clk);
      nrst <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         wr(AXIS_STRIDE + OFS_ENV5, 32'(c) << SYO_LSB);
         for (int i = 0; i < EV_N; i++) begin
            pulse_ev(1, i);
            chk(sync_y, exp_sync(c, i), "timing code");
         end
      end
      sync_case(0, 1, 4'h9, 1);
      sync_case(1, 0, SYO_CMP1, 4);
      arm_stop(0, MAX_Y);
      rd(OFS_XSTS, rd_v);
      chk(rd_v, 32'(WAIT_STOP), "wait stop");
      run(1, 8'h05);
      wait_go(0, 2'b10);
      arm_stop(1, MAX_XY);
      run(0, 8'h04);
      wait_go(1, 2'b01);
      // legacy: x running and naming itself must never start; it stays armed for the enhanced case
      run(0, 8'h0A);
      arm_stop(0, MAX_X);
      repeat (16) begin
         @(posedge ref_clk);
         #1 seen = seen | go_x;
      end
      chk(seen, 0, "legacy self start");
      wr(OFS_ENV2, 32'h1 << SMAX_BIT);
      run(0, 8'h0A);
      arm_stop(0, MAX_X);
      wait_go(0, 2'b01);
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < EV_N; i++) begin
            en = j ? 1'b1 : 1'($urandom_range(0, 1));
            wr(AXIS_STRIDE + OFS_IRQ_EN, 32'(en) << (EV_LSB + i));
            pulse_ev(1, i);
            chk(irq, en, "irq");
            rd(AXIS_STRIDE + OFS_IRQ_CAUSE, rd_v);
            chk(rd_v, 32'(en) << (EV_LSB + i), "cause");
            chk(irq, en, "irq level");
            wr(AXIS_STRIDE + OFS_IRQ_CAUSE, 32'h0000_1FF0);
            rd(AXIS_STRIDE + OFS_IRQ_CAUSE, rd_v);
            chk(rd_v, 0, "cause clear");
            chk(irq, 0, "irq clear");
         end
      end
      wr(6'h18, $urandom());
      rd(6'h18, rd_v);
      chk(rd_v, 0, "unmapped");
      rd(OFS_MODE, rd_v);
      chk(rd_v, 0, "write-only");
      print_verdict();
   end
endmodule : tb_top
